// >>> logic/ofr_pkg.sv
// Package for the output function router: register map, field layout, function codes.
// Assumes a 32-bit AHB-Lite register bus and three output pins.
package ofr_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] SEL1_OFS = 8'h00;
  localparam logic [7:0] SEL2_OFS = 8'h04;
  localparam logic [7:0] SEL3_OFS = 8'h08;
  localparam logic [7:0] CTRL_OFS = 8'h0c;
  localparam logic [7:0] STAT_OFS = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h18;
  localparam logic [7:0] IRQ_EN_OFS = 8'h1c;
  localparam logic [7:0] OUT_OFS = 8'h20;

  // ==========================================================
  // Reset values and field layout
  localparam logic [23:0] SEL1_RST = 24'h030303;
  localparam logic [23:0] SEL2_RST = 24'h101010;
  localparam logic [23:0] SEL3_RST = 24'h010101;
  localparam logic [23:0] SEL_MASK = 24'hffffff;
  localparam int POS_LSB = 0;
  localparam int VEL_LSB = 8;
  localparam int TRQ_LSB = 16;
  localparam int CTRL_INIT_DONE_BIT = 0;
  localparam int CTRL_BRAKE_OBJ_BIT = 1;
  localparam int CTRL_GP_OUT_BIT = 2;
  localparam int STAT_ERR_BRK_BIT = 0;
  localparam int STAT_ERR_SOFT_BIT = 1;
  localparam int STAT_MODE_LSB = 4;

  // ==========================================================
  // Control modes
  typedef enum logic [1:0]
  {
    MODE_POS = 2'h0,
    MODE_VEL = 2'h1,
    MODE_TRQ = 2'h2
  } ofr_mode_e;

  // Function numbers
  localparam logic [7:0] FN_OFF = 8'h00;
  localparam logic [7:0] FN_BRAKE_REL = 8'h03;
  localparam logic [7:0] FN_SOFT_BRAKE = 8'h11;
  localparam logic [7:0] FN_LAST = 8'h11;

  // Internal status functions, bit n-1 is function n
  typedef struct packed
  {
    logic velocity_cmd;
    logic alarm_attribute;
    logic speed_limited;
    logic positioning_done_two;
    logic position_cmd;
    logic warning_two;
    logic warning_one;
    logic velocity_match;
    logic zero_velocity;
    logic torque_limited;
    logic at_velocity;
    logic positioning_done;
    logic brake_release;
    logic servo_ready;
    logic alarm;
  } ofr_status_s;

  typedef struct packed
  {
    logic [7:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
  } ofr_addr_s;
endpackage

// >>> logic/ofr_pin_drive.sv
// One output pin: picks the active mode byte and decodes it to a function level.
// Assumes status inputs are already synchronous to ref_clk.
`timescale 1ns/1ps
module ofr_pin_drive
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [23:0] sel,
  input wire ofr_pkg::ofr_mode_e mode,
  input wire logic [16:0] func_vec,
  input wire logic outputs_allowed,
  output logic pin_on
);
  logic pin_r;
  logic [7:0] fn_pos;
  logic [7:0] fn_vel;
  logic [7:0] fn_trq;
  logic [7:0] fn_active;
  logic fn_defined;
  logic fn_level;

  assign fn_pos = sel[ofr_pkg::POS_LSB +: 8];
  assign fn_vel = sel[ofr_pkg::VEL_LSB +: 8];
  assign fn_trq = sel[ofr_pkg::TRQ_LSB +: 8];
  assign fn_active = (mode == ofr_pkg::MODE_VEL) ? fn_vel :
                     (mode == ofr_pkg::MODE_TRQ) ? fn_trq : fn_pos;
  // Zero and codes beyond the table both fall out as off
  assign fn_defined = (fn_active != ofr_pkg::FN_OFF) && (fn_active <= ofr_pkg::FN_LAST);
  assign fn_level = fn_defined ? func_vec[fn_active[4:0] - 5'h01] : 1'b0;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      pin_r <= 1'b0;
    else
      pin_r <= fn_level & outputs_allowed;
  end

  assign pin_on = pin_r;
endmodule

// >>> logic/ofr_ahb_slave.sv
// AHB-Lite slave front end: latches the address phase, answers with zero wait states.
// Assumes single word transfers; the response is always OKAY.
`timescale 1ns/1ps
module ofr_ahb_slave
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] acc_addr
);
  ofr_pkg::ofr_addr_s addr_r;
  logic wr_pend_r;
  logic rd_pend_r;
  logic take;

  assign take = hsel & hready & htrans[1];

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_r <= '0;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
    end
    else
    begin
      wr_pend_r <= take & hwrite;
      rd_pend_r <= take & ~hwrite;
      if (take)
        addr_r <= '{haddr: haddr[7:0], hwrite: hwrite, hsize: hsize};
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_en = wr_pend_r;
  assign rd_en = rd_pend_r;
  assign acc_addr = addr_r.haddr;
endmodule

// >>> logic/ofr_top.sv
// Output function router top: selection registers, mode handling, brake checks, interrupts.
// Assumes drive status inputs come from logic on ref_clk; the brake object and init flag from software.
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module ofr_top
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire ofr_pkg::ofr_mode_e control_mode,
  input wire ofr_pkg::ofr_status_s drive_status,
  output logic output_pin_one,
  output logic output_pin_two,
  output logic output_pin_three,
  output logic irq
);
  // ==========================================================
  // Bus front end
  logic wr_en;
  logic rd_en;
  logic [7:0] acc_addr;

  ofr_ahb_slave u_bus
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .acc_addr(acc_addr)
  );

  // ==========================================================
  // Registers
  logic [23:0] sel_r [3];
  logic init_done_r;
  logic brake_obj_r;
  logic gp_out_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_stat_nxt;
  logic [1:0] irq_en_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [2:0] pin_vec;

  wire wr_sel1 = wr_en && (acc_addr == ofr_pkg::SEL1_OFS);
  wire wr_sel2 = wr_en && (acc_addr == ofr_pkg::SEL2_OFS);
  wire wr_sel3 = wr_en && (acc_addr == ofr_pkg::SEL3_OFS);
  wire wr_ctrl = wr_en && (acc_addr == ofr_pkg::CTRL_OFS);
  wire wr_clr = wr_en && (acc_addr == ofr_pkg::IRQ_CLR_OFS);
  wire wr_ien = wr_en && (acc_addr == ofr_pkg::IRQ_EN_OFS);

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sel_r[0] <= ofr_pkg::SEL1_RST;
      sel_r[1] <= ofr_pkg::SEL2_RST;
      sel_r[2] <= ofr_pkg::SEL3_RST;
      init_done_r <= 1'b0;
      brake_obj_r <= 1'b0;
      gp_out_r <= 1'b0;
      irq_en_r <= 2'h0;
    end
    else
    begin
      // Range limit: upper byte never stored
      if (wr_sel1)
        sel_r[0] <= hwdata[23:0] & ofr_pkg::SEL_MASK;
      if (wr_sel2)
        sel_r[1] <= hwdata[23:0] & ofr_pkg::SEL_MASK;
      if (wr_sel3)
        sel_r[2] <= hwdata[23:0] & ofr_pkg::SEL_MASK;
      if (wr_ctrl)
      begin
        init_done_r <= hwdata[ofr_pkg::CTRL_INIT_DONE_BIT];
        brake_obj_r <= hwdata[ofr_pkg::CTRL_BRAKE_OBJ_BIT];
        gp_out_r <= hwdata[ofr_pkg::CTRL_GP_OUT_BIT];
      end
      if (wr_ien)
        irq_en_r <= hwdata[1:0];
    end
  end

  // ==========================================================
  // Brake assignment consistency check
  function automatic logic partial_assign(input logic [23:0] s, input logic [7:0] fn);
    logic [2:0] hit;
    hit = {s[23:16] == fn, s[15:8] == fn, s[7:0] == fn};
    partial_assign = (hit != 3'h0) && (hit != 3'h7);
  endfunction

  logic err_brk;
  logic err_soft;
  always_comb
  begin
    err_brk = 1'b0;
    err_soft = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      err_brk = err_brk | partial_assign(sel_r[i], ofr_pkg::FN_BRAKE_REL);
      err_soft = err_soft | partial_assign(sel_r[i], ofr_pkg::FN_SOFT_BRAKE);
    end
  end

  // Error holds outputs off too, so a broken brake setup cannot release it
  wire outputs_allowed = init_done_r & ~err_brk & ~err_soft;

  // Set wins over a clear in the same cycle
  assign irq_stat_nxt = (irq_stat_r & ~(wr_clr ? hwdata[1:0] : 2'h0)) | {err_soft, err_brk};

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      irq_stat_r <= 2'h0;
    else
      irq_stat_r <= irq_stat_nxt;
  end

  assign irq = |(irq_stat_r & irq_en_r);

  // ==========================================================
  // Function vector and pin drivers
  logic [16:0] func_vec;
  // General output one is a software-owned level, like the brake object
  assign func_vec = {~brake_obj_r, gp_out_r, drive_status};

  for (genvar p = 0; p < 3; p++)
  begin : g_pin
    ofr_pin_drive u_pin
    (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .sel(sel_r[p]),
      .mode(control_mode),
      .func_vec(func_vec),
      .outputs_allowed(outputs_allowed),
      .pin_on(pin_vec[p])
    );
  end

  assign output_pin_one = pin_vec[0];
  assign output_pin_two = pin_vec[1];
  assign output_pin_three = pin_vec[2];

  // ==========================================================
  // Read data
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    unique case (acc_addr)
      ofr_pkg::SEL1_OFS: rdata_nxt = {8'h00, sel_r[0]};
      ofr_pkg::SEL2_OFS: rdata_nxt = {8'h00, sel_r[1]};
      ofr_pkg::SEL3_OFS: rdata_nxt = {8'h00, sel_r[2]};
      ofr_pkg::CTRL_OFS: rdata_nxt = {29'h0, gp_out_r, brake_obj_r, init_done_r};
      ofr_pkg::STAT_OFS: rdata_nxt = {26'h0, control_mode, 2'h0, err_soft, err_brk};
      ofr_pkg::IRQ_STAT_OFS: rdata_nxt = {30'h0, irq_stat_r};
      ofr_pkg::IRQ_EN_OFS: rdata_nxt = {30'h0, irq_en_r};
      ofr_pkg::OUT_OFS: rdata_nxt = {29'h0, pin_vec};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Read data is combinational from registers during the data phase
  assign rdata_r = rd_en ? rdata_nxt : 32'h0000_0000;
  assign hrdata = rdata_r;
endmodule

// >>> tb/ofr_checker.sv
// Checker for the output router: bus answers, init gating, interrupt behaviour.
// Assumes it is bound to ofr_top and sees only its ports.
`timescale 1ns/1ps
module ofr_checker
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic output_pin_one,
  input wire logic output_pin_two,
  input wire logic output_pin_three,
  input wire logic irq
);
  // ====
  // Shadow of the data phase and the init flag
  logic dp_r;
  logic wr_r;
  logic [7:0] a_r;
  logic init_r;
  wire pins = output_pin_one | output_pin_two | output_pin_three;
  wire wr_dp = dp_r & wr_r;
  wire ctrl_wr = wr_dp & (a_r == ofr_pkg::CTRL_OFS);
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dp_r <= 1'b0;
      wr_r <= 1'b0;
      a_r <= 8'h00;
      init_r <= 1'b0;
    end
    else
    begin
      dp_r <= hsel & hready & htrans[1];
      wr_r <= hwrite;
      a_r <= haddr[7:0];
      if (ctrl_wr)
        init_r <= hwdata[ofr_pkg::CTRL_INIT_DONE_BIT];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ====
  // Assertions
  a_bus_ready: assert property (hreadyout) else $error("hreadyout low");
  a_bus_okay: assert property (!hresp) else $error("hresp not okay");
  a_rdata_idle: assert property (!dp_r |-> hrdata == 32'h0) else $error("hrdata outside data phase");
  a_sel_upper: assert property (dp_r && !wr_r && a_r <= ofr_pkg::SEL3_OFS |-> hrdata[31:24] == 8'h00)
    else $error("selection upper byte set");
  a_init_gate: assert property (!init_r |=> !pins) else $error("pin on before init");
  a_reset_off: assert property ($rose(resetn) |-> !pins) else $error("pin on after reset");
  a_irq_reset: assert property ($rose(resetn) |-> !irq) else $error("irq after reset");
  a_irq_clear: assert property ($fell(irq) |-> $past(wr_dp)) else $error("irq fell without write");
  c_pin_rise: cover property ($rose(output_pin_one));
  c_irq_rise: cover property ($rose(irq));
  c_ctrl_wr: cover property (ctrl_wr);
endmodule

// >>> tb/ofr_load_model.sv
// Load on the pins: brake relay on pin one, host inputs on the others.
// Assumes pins are sampled on ref_clk; LAG is the pick-up delay of the load.
`timescale 1ns/1ps
module ofr_load_model
#(
  parameter int LAG = 2
)
(
  input wire logic ref_clk,
  input wire logic [2:0] pins,
  output logic [2:0] seen
);
  logic [2:0] pipe_r [LAG];
  always_ff @(posedge ref_clk)
  begin
    pipe_r[0] <= pins;
    for (int i = 1; i < LAG; i++)
      pipe_r[i] <= pipe_r[i - 1];
  end
  assign seen = pipe_r[LAG - 1];
endmodule

// >>> tb/tb.sv
// Testbench for ofr_top: AHB-Lite master tasks and pin checks through the load model.
// Assumes one slave, so hready is the slave's own hreadyout.
`timescale 1ns/1ps
module tb;
  logic ref_clk;
  logic resetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic [14:0] pat;
  logic [2:0] pins;
  logic [2:0] seen;
  ofr_pkg::ofr_mode_e control_mode;
  ofr_pkg::ofr_status_s drive_status;
  int err_count;
  int check_count;
  ofr_top dut (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .control_mode(control_mode), .drive_status(drive_status), .output_pin_one(pins[0]),
    .output_pin_two(pins[1]), .output_pin_three(pins[2]), .irq(irq));
  ofr_load_model ld (.ref_clk(ref_clk), .pins(pins), .seen(seen));
  // ====
  // Tasks
  task automatic give_verdict;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      err_count++;
      $display("mismatch %0t bus timeout", $time);
      give_verdict;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Register to pin and load pick-up take three edges
  task automatic settle;
    repeat (5) @(posedge ref_clk);
  endtask
  function automatic logic fn(input int c, input logic [14:0] s, input logic b, input logic g);
    if (c >= 1 && c <= 15)
      return s[c - 1];
    if (c == 16)
      return g;
    if (c == 17)
      return ~b;
    return 1'b0;
  endfunction
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ====
  // Main sequence
  initial
  begin
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    control_mode = ofr_pkg::MODE_POS;
    drive_status = 15'h7fff;
    err_count = 0;
    check_count = 0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rd(ofr_pkg::SEL1_OFS, 32'h00030303);
    rd(ofr_pkg::SEL2_OFS, 32'h00101010);
    rd(ofr_pkg::SEL3_OFS, 32'h00010101);
    rd(8'h40, 32'h0);
    settle;
    chk(seen, 3'h0);
    bus(1'b1, ofr_pkg::CTRL_OFS, 32'h5);
    settle;
    chk(seen, 3'h7);
    // Codes above 11h are written on purpose to see them refused
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 20; c++)
      begin
        pat = p ? 15'h2b5c : 15'h54a3;
        drive_status <= pat;
        control_mode <= ofr_pkg::ofr_mode_e'(c % 3);
        bus(1'b1, ofr_pkg::CTRL_OFS, {29'h0, p[0], p[0], 1'b1});
        bus(1'b1, ofr_pkg::SEL1_OFS, {8'h0, {3{c[7:0]}}});
        settle;
        chk(seen[0], fn(c, pat, p[0], p[0]));
      end
    drive_status <= 15'h0011;
    bus(1'b1, ofr_pkg::SEL1_OFS, 32'hff010205);
    rd(ofr_pkg::SEL1_OFS, 32'h00010205);
    for (int m = 0; m < 3; m++)
    begin
      control_mode <= ofr_pkg::ofr_mode_e'(m);
      settle;
      chk(seen[0], m != 1);
    end
    bus(1'b1, ofr_pkg::IRQ_EN_OFS, 32'h3);
    bus(1'b1, ofr_pkg::SEL3_OFS, 32'h00000003);
    settle;
    rd(ofr_pkg::STAT_OFS, 32'h00000021);
    chk({irq, seen}, 4'h8);
    bus(1'b1, ofr_pkg::SEL3_OFS, 32'h00001100);
    settle;
    rd(ofr_pkg::IRQ_STAT_OFS, 32'h3);
    bus(1'b1, ofr_pkg::IRQ_EN_OFS, 32'h0);
    settle;
    chk(irq, 1'b0);
    bus(1'b1, ofr_pkg::SEL3_OFS, 32'h00010101);
    bus(1'b1, ofr_pkg::IRQ_CLR_OFS, 32'h3);
    bus(1'b1, ofr_pkg::IRQ_EN_OFS, 32'h3);
    settle;
    rd(ofr_pkg::IRQ_STAT_OFS, 32'h0);
    chk({irq, seen[2], seen[0]}, 3'h3);
    bus(1'b1, ofr_pkg::CTRL_OFS, 32'h0);
    settle;
    chk(seen, 3'h0);
    bus(1'b1, ofr_pkg::CTRL_OFS, 32'h1);
    resetn <= 1'b0;
    settle;
    chk(seen, 3'h0);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rd(ofr_pkg::SEL1_OFS, 32'h00030303);
    settle;
    chk(seen, 3'h0);
    give_verdict;
  end
endmodule
bind ofr_top ofr_checker u_chk (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .output_pin_one(output_pin_one), .output_pin_two(output_pin_two), .output_pin_three(output_pin_three), .irq(irq));
